// file: src/smie_map.svh
// Offsets, instruction field positions, reset values and step constants
// Assumes inclusion by the core file only; definitions only
`ifndef SMIE_MAP_SVH
`define SMIE_MAP_SVH

// ==========================================================
// APB register byte offsets
`define SMIE_OFS_INSTR 8'h00
`define SMIE_OFS_ACC   8'h04
`define SMIE_OFS_PTR0  8'h08
`define SMIE_OFS_PTR1  8'h0c
`define SMIE_OFS_STAT  8'h10

// ==========================================================
// Instruction word fields
`define SMIE_F_OP_MSB   13
`define SMIE_F_OP_LSB   12
`define SMIE_F_REL      8
`define SMIE_F_DEST     7
`define SMIE_F_FA_MSB   6
`define SMIE_F_SEL      6
`define SMIE_F_K_MSB    5
`define SMIE_F_MM_MSB   1

// ==========================================================
// Status register bits
`define SMIE_ST_OVF  0
`define SMIE_ST_ZERO 1
`define SMIE_ST_BUSY 2

// ==========================================================
// Window addresses, reset values, pointer step
`define SMIE_WIN0_ADDR 7'h00
`define SMIE_WIN1_ADDR 7'h01
`define SMIE_ACC_RST   8'h00
`define SMIE_PTR_RST   16'h0000
`define SMIE_PTR_STEP  16'h0001
`define SMIE_MM_PREINC  2'h0
`define SMIE_MM_PREDEC  2'h1
`define SMIE_MM_POSTINC 2'h2
`define SMIE_MM_POSTDEC 2'h3

`endif

// file: src/smie_pkg.sv
// Types shared by the execution slice
// Assumes nothing beyond a SystemVerilog compiler
package smie_pkg;

   // ==========================================================
   // Sequencer states and operations
   typedef enum logic [1:0] {
      st_idle,
      st_read,
      st_capture,
      st_finish
   } smie_state_e;

   typedef enum logic [1:0] {
      op_shift_right,
      op_copy,
      op_indirect,
      op_none
   } smie_op_e;

   // ==========================================================
   // Data memory request carrier
   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } smie_mem_req_s;

   // ==========================================================
   // Whole state of the core
   typedef struct packed {
      smie_state_e   state;
      smie_op_e      op;
      logic          dest;
      logic          busy;
      logic [15:0]   ea;
      logic [7:0]    acc;
      logic [15:0]   ptr0;
      logic [15:0]   ptr1;
      logic          ovf;
      logic          zero;
      smie_mem_req_s mem;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } smie_regs_s;

endpackage

// file: src/smie_core.sv
// Execution slice: right shift, register copy and indirect load
// Assumes an APB master and a data memory with one-cycle read latency
// Assumes software polls busy, since any write while busy is refused
//
// Function
// [RQ1] Right shift puts zero in bit 7, bits 7..1 into 6..0, bit 0 to overflow.
// [RQ2] Right shift result goes to the accumulator when dest is 0, else to f.
// [RQ3] Copy sends f to the accumulator when dest is 0, else rewrites f.
// [RQ4] Copy updates the zero flag from the moved value for both targets.
// [RQ5] Indirect load copies data at the effective address into accumulator.
// [RQ6] After indirect load the pointer is +1, -1 or unchanged by mode.
// [RQ7] Update kind 00 preinc, 01 predec, 10 postinc, 11 postdec.
// [RQ8] Relative mode adds a signed offset of -32..31 to the pointer.
// [RQ9] A select bit picks which pointer and window the load uses.
// [RQ10] The window address has no storage and maps to the pointed location.
// [RQ11] Pointers span 0000h..FFFFh and wrap on step past either end.
// [RQ12] Right shift and indirect load set zero when the result is zero.
`include "smie_map.svh"

module smie_core
   import smie_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          arst_n,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic               pready,
   output logic               pslverr,
   output logic [31:0]        prdata,
   // Data memory port
   output smie_mem_req_s      mem_req,
   input  wire logic [7:0]    mem_rdata,
   // Core status
   output logic               busy
);

   // ==========================================================
   // Helpers

   // Sixteen-bit add keeps the pointer modulo its range
   function automatic logic [15:0] ptr_step(
      input logic [15:0] p,
      input logic        down
   );
      // [RQ11] wrap on step
      ptr_step = down ? p - `SMIE_PTR_STEP : p + `SMIE_PTR_STEP;
   endfunction

   function automatic logic [15:0] file_addr(
      input logic [6:0]  f,
      input logic [15:0] p0,
      input logic [15:0] p1
   );
      // [RQ10] window redirects access
      if (f == `SMIE_WIN0_ADDR) begin
         file_addr = p0;
      end else if (f == `SMIE_WIN1_ADDR) begin
         file_addr = p1;
      end else begin
         file_addr = {9'h000, f};
      end
   endfunction

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0]  strb
   );
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // Zero fills from the top; the low bit leaves through overflow
   function automatic logic [7:0] shift_right(
      input logic [7:0] v
   );
      // [RQ1] zero into bit 7
      shift_right = {1'b0, v[7:1]};
   endfunction

   // Offsets are six-bit two's complement, widened to pointer width
   function automatic logic [15:0] sign_ext6(
      input logic [5:0] k
   );
      // [RQ8] signed offset range
      sign_ext6 = {{10{k[5]}}, k};
   endfunction

   // Pointer that the select bit names
   function automatic logic [15:0] pick_ptr(
      input logic        sel,
      input logic [15:0] p0,
      input logic [15:0] p1
   );
      // [RQ9] pointer select
      pick_ptr = sel ? p1 : p0;
   endfunction

   // Zero test for the result flag
   function automatic logic is_zero(
      input logic [7:0] v
   );
      is_zero = (v == 8'h00);
   endfunction

   // Pointers read back zero-extended to the bus width
   function automatic logic [31:0] ptr_word(
      input logic [15:0] p
   );
      ptr_word = {16'h0000, p};
   endfunction

   // Status word as software reads it; unused bits read as zero
   function automatic logic [31:0] status_word(
      input logic ovf,
      input logic zero,
      input logic bsy
   );
      status_word = 32'h0000_0000;
      status_word[`SMIE_ST_OVF]  = ovf;
      status_word[`SMIE_ST_ZERO] = zero;
      status_word[`SMIE_ST_BUSY] = bsy;
   endfunction

   // ==========================================================
   // State

   smie_regs_s cur;
   smie_regs_s next_cur;

   assign pready  = cur.pready;
   assign pslverr = cur.pslverr;
   assign prdata  = cur.prdata;
   assign mem_req = cur.mem;
   assign busy    = cur.busy;

   // ==========================================================
   // Next-state logic

   always_comb begin
      logic        setup;
      logic        wr_req;
      logic        start;
      logic [15:0] instr;
      logic [15:0] ptr;
      logic [15:0] new_ptr;
      logic [15:0] ofs;
      logic [1:0]  kind;
      logic [7:0]  res;
      smie_op_e    op;
      setup   = 1'b0;
      wr_req  = 1'b0;
      start   = 1'b0;
      instr   = 16'h0000;
      ptr     = 16'h0000;
      new_ptr = 16'h0000;
      ofs     = 16'h0000;
      kind    = 2'h0;
      res     = 8'h00;
      op      = op_none;
      next_cur = cur;
      next_cur.pready  = 1'b0;
      next_cur.pslverr = 1'b0;
      next_cur.mem.rd  = 1'b0;
      next_cur.mem.wr  = 1'b0;

      // Answer in the setup cycle so pready is high in the first access
      setup  = psel && !penable;
      wr_req = setup && pwrite;

      // ==========================================================
      // APB register access
      if (setup) begin
         next_cur.pready = 1'b1;
         next_cur.prdata = 32'h0000_0000;
         if (paddr == `SMIE_OFS_INSTR) begin
            if (wr_req) begin
               instr = merge16(16'h0000, pwdata, pstrb);
               op    = smie_op_e'(instr[`SMIE_F_OP_MSB:`SMIE_F_OP_LSB]);
               // Writes while an instruction runs would race the sequencer
               if (cur.busy || op == op_none) begin
                  next_cur.pslverr = 1'b1;
               end else begin
                  start = 1'b1;
               end
            end
         end else if (paddr == `SMIE_OFS_ACC) begin
            if (wr_req && cur.busy) begin
               next_cur.pslverr = 1'b1;
            end else if (wr_req && pstrb[0]) begin
               next_cur.acc = pwdata[7:0];
            end
            next_cur.prdata = {24'h00_0000, cur.acc};
         end else if (paddr == `SMIE_OFS_PTR0) begin
            if (wr_req && cur.busy) begin
               next_cur.pslverr = 1'b1;
            end else if (wr_req) begin
               next_cur.ptr0 = merge16(cur.ptr0, pwdata, pstrb);
            end
            next_cur.prdata = ptr_word(cur.ptr0);
         end else if (paddr == `SMIE_OFS_PTR1) begin
            if (wr_req && cur.busy) begin
               next_cur.pslverr = 1'b1;
            end else if (wr_req) begin
               next_cur.ptr1 = merge16(cur.ptr1, pwdata, pstrb);
            end
            next_cur.prdata = ptr_word(cur.ptr1);
         end else if (paddr == `SMIE_OFS_STAT) begin
            if (wr_req && cur.busy) begin
               next_cur.pslverr = 1'b1;
            end else if (wr_req && pstrb[0]) begin
               next_cur.ovf  = pwdata[`SMIE_ST_OVF];
               next_cur.zero = pwdata[`SMIE_ST_ZERO];
            end
            next_cur.prdata = status_word(cur.ovf, cur.zero, cur.busy);
         end else begin
            next_cur.pslverr = 1'b1;
         end
      end

      // ==========================================================
      // Instruction sequencer
      case (cur.state)
         st_idle: begin
            if (start) begin
               next_cur.op    = op;
               next_cur.dest  = instr[`SMIE_F_DEST];
               next_cur.state = st_read;
               next_cur.mem.rd = 1'b1;
               if (op == op_indirect) begin
                  // [RQ9] pointer select
                  ptr  = pick_ptr(instr[`SMIE_F_SEL], cur.ptr0, cur.ptr1);
                  kind = instr[`SMIE_F_MM_MSB:0];
                  // Indirect load always targets the accumulator
                  next_cur.dest = 1'b0;
                  if (instr[`SMIE_F_REL]) begin
                     // [RQ8] signed offset
                     ofs = sign_ext6(instr[`SMIE_F_K_MSB:0]);
                     next_cur.ea = ptr + ofs;
                     new_ptr = ptr;
                  end else begin
                     // [RQ7] update kind decode
                     case (kind)
                        `SMIE_MM_PREINC: begin
                           new_ptr     = ptr_step(ptr, 1'b0);
                           next_cur.ea = new_ptr;
                        end
                        `SMIE_MM_PREDEC: begin
                           new_ptr     = ptr_step(ptr, 1'b1);
                           next_cur.ea = new_ptr;
                        end
                        `SMIE_MM_POSTINC: begin
                           new_ptr     = ptr_step(ptr, 1'b0);
                           next_cur.ea = ptr;
                        end
                        default: begin
                           new_ptr     = ptr_step(ptr, 1'b1);
                           next_cur.ea = ptr;
                        end
                     endcase
                  end
                  // [RQ6] pointer after access
                  if (instr[`SMIE_F_SEL]) begin
                     next_cur.ptr1 = new_ptr;
                  end else begin
                     next_cur.ptr0 = new_ptr;
                  end
               end else begin
                  next_cur.ea = file_addr(instr[`SMIE_F_FA_MSB:0],
                                          cur.ptr0, cur.ptr1);
               end
               next_cur.mem.addr = next_cur.ea;
            end
         end
         st_read: begin
            // Memory samples the read here; data follows next cycle
            next_cur.state = st_capture;
         end
         st_capture: begin
            case (cur.op)
               op_shift_right: begin
                  // [RQ1] shift right
                  res          = shift_right(mem_rdata);
                  next_cur.ovf = mem_rdata[0];
               end
               default: begin
                  // [RQ5] load or copy value
                  res = mem_rdata;
               end
            endcase
            // [RQ4] [RQ12] zero flag
            next_cur.zero = is_zero(res);
            // [RQ2] [RQ3] target select
            if (cur.dest) begin
               next_cur.mem.wr    = 1'b1;
               next_cur.mem.addr  = cur.ea;
               next_cur.mem.wdata = res;
            end else begin
               next_cur.acc = res;
            end
            next_cur.state = st_finish;
         end
         default: begin
            // Write-back pulse ends here; busy drops on the return to idle
            next_cur.state = st_idle;
         end
      endcase

      next_cur.busy = (next_cur.state != st_idle);
   end

   // ==========================================================
   // State register

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur.state     <= st_idle;
         cur.op        <= op_none;
         cur.dest      <= 1'b0;
         cur.busy      <= 1'b0;
         cur.ea        <= 16'h0000;
         cur.acc       <= `SMIE_ACC_RST;
         cur.ptr0      <= `SMIE_PTR_RST;
         cur.ptr1      <= `SMIE_PTR_RST;
         cur.ovf       <= 1'b0;
         cur.zero      <= 1'b0;
         cur.mem       <= '0;
         cur.pready    <= 1'b0;
         cur.pslverr   <= 1'b0;
         cur.prdata    <= 32'h0000_0000;
      end else begin
         cur <= next_cur;
      end
   end

endmodule

// file: testbench/smie_core_asserts.sv
// Port-level checker for the execution slice
// Assumes it is bound onto smie_core and sees only its ports
module smie_core_asserts
   import smie_pkg::*;
(
   // Clock and reset
   input wire logic          sys_clk,
   input wire logic          arst_n,
   // APB
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic [31:0]   prdata,
   // Memory and status
   input wire smie_mem_req_s mem_req,
   input wire logic [7:0]    mem_rdata,
   input wire logic          busy
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_ready;
      psel && !penable |=> pready && penable;
   endproperty
   a_ready: assert property (p_ready) else $error("no zero-wait ready");
   property p_ready_in_access;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("ready outside access");
   property p_unmapped;
      psel && !penable && !pwrite && paddr > 8'h10
         |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_refuse_busy;
      psel && !penable && pwrite && busy |=> pslverr;
   endproperty
   a_refuse_busy: assert property (p_refuse_busy)
      else $error("write during busy accepted");
   property p_busy_len;
      $rose(busy) |-> mem_req.rd ##0 busy [*3] ##1 !busy;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length");
   property p_rd_pulse;
      mem_req.rd |-> busy ##1 !mem_req.rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read pulse");
   property p_wr_addr;
      mem_req.wr |-> busy && $past(mem_req.rd, 2)
         && mem_req.addr == $past(mem_req.addr, 2) ##1 !mem_req.wr;
   endproperty
   a_wr_addr: assert property (p_wr_addr)
      else $error("write-back addr");
   property p_wr_data;
      mem_req.wr |-> mem_req.wdata == $past(mem_rdata)
         || mem_req.wdata == {1'b0, $past(mem_rdata[7:1])};
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write-back data");
endmodule

bind smie_core smie_core_asserts i_asserts (.sys_clk(sys_clk),
   .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .mem_req(mem_req),
   .mem_rdata(mem_rdata), .busy(busy));

// file: testbench/smie_core_bench.sv
// Self-checking bench for the execution slice
// Assumes the bench is the APB master and the data memory
module smie_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import smie_pkg::*;
   logic          sys_clk = 1'b0;
   logic          arst_n = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0;
   logic [3:0]    pstrb = 4'hf;
   logic          pready;
   logic          pslverr;
   logic [31:0]   prdata;
   smie_mem_req_s mem_req;
   logic [7:0]    mem_rdata = 8'h00;
   logic          busy;
   logic [7:0]    mem [0:65535];
   logic [31:0]   rd_data;
   logic          rd_err;
   int            mismatches = 0;
   int            tests_run = 0;
   int            cycles = 0;

   smie_core i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy));

   // ==========================================================
   // Clock, memory, timeout
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // Idle read data toggles so a stale byte is never mistaken for a hit
   always @(posedge sys_clk) begin
      if (mem_req.wr === 1'b1) mem[mem_req.addr] <= mem_req.wdata;
      mem_rdata <= (mem_req.rd === 1'b1) ? mem[mem_req.addr] : ~mem_rdata;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string s, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [31:0] ins);
      apb(1'b1, 8'h00, ins);
      do apb(1'b0, 8'h10, 32'h0); while (rd_data[2] !== 1'b0);
   endtask
   task automatic rd(input string s, input logic [7:0] a,
                     input logic [15:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd_data[15:0]);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_shift();
      mem[16'h0055] = 8'h81;
      mem[16'h0056] = 8'h01;
      run(32'h0000_0055);
      chk("shift stat", 16'h0001, rd_data[15:0]);
      rd("shift acc", 8'h04, 16'h0040);
      run(32'h0000_00d6);
      chk("shift f stat", 16'h0003, rd_data[15:0]);
      chk("shift f", 16'h0000, {8'h00, mem[16'h0056]});
      rd("acc kept", 8'h04, 16'h0040);
   endtask
   task automatic t_copy();
      mem[16'h0020] = 8'h00;
      mem[16'h0021] = 8'h5a;
      run(32'h0000_10a0);
      chk("copy f stat", 16'h0003, rd_data[15:0]);
      chk("copy f", 16'h0000, {8'h00, mem[16'h0020]});
      apb(1'b1, 8'h00, 32'h0000_1021);
      apb(1'b1, 8'h04, 32'h0000_0099);
      chk("busy write err", 16'h0001, {15'h0, rd_err});
      // Op code 3 is refused at once, so no status poll follows
      apb(1'b1, 8'h00, 32'h0000_3000);
      chk("bad op err", 16'h0001, {15'h0, rd_err});
      rd("copy acc", 8'h04, 16'h005a);
      apb(1'b1, 8'h08, 32'h0000_1234);
      mem[16'h1234] = 8'h77;
      run(32'h0000_1000);
      chk("window stat", 16'h0001, rd_data[15:0]);
      rd("window acc", 8'h04, 16'h0077);
      rd("unmapped", 8'h14, 16'h0000);
      chk("unmapped err", 16'h0001, {15'h0, rd_err});
   endtask
   task automatic t_reset();
      apb(1'b1, 8'h04, 32'h0000_00a5);
      rd("acc write", 8'h04, 16'h00a5);
      apb(1'b1, 8'h0c, 32'h0000_5a5a);
      pstrb <= 4'h2;
      apb(1'b1, 8'h0c, 32'h0000_c3c3);
      pstrb <= 4'hf;
      rd("lane merge", 8'h0c, 16'hc35a);
      // Second reset, applied while the core is idle, must clear every register again
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int a = 4; a <= 16; a += 4) rd("mid reset", 8'(a), 16'h0000);
   endtask
   task automatic t_ind(input logic s, r, input logic [5:0] v,
                        input logic [15:0] p);
      logic [15:0] ea;
      logic [15:0] np;
      ea = r ? p + {{10{v[5]}}, v} : v[1] ? p : v[0] ? p - 16'h1 : p + 16'h1;
      np = r ? p : v[0] ? p - 16'h1 : p + 16'h1;
      mem[ea] = ea[15:8];
      apb(1'b1, s ? 8'h0c : 8'h08, {16'h0, p});
      apb(1'b1, s ? 8'h08 : 8'h0c, {16'h0, ~p});
      run({18'h0, 2'h2, 3'h0, r, 1'b0, s, v});
      chk("ind zero", {15'h0, ea[15:8] == 8'h00},
          {15'h0, rd_data[1]});
      rd("ind acc", 8'h04, {8'h00, ea[15:8]});
      rd("ind ptr", s ? 8'h0c : 8'h08, np);
      rd("other ptr", s ? 8'h08 : 8'h0c, ~p);
   endtask

   // ==========================================================
   // Main sequence
   task automatic results();
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int a = 4; a <= 16; a += 4) rd("reset", 8'(a), 16'h0000);
      t_shift();
      t_copy();
      t_reset();
      t_ind(1'b0, 1'b0, 6'h00, 16'hffff);
      t_ind(1'b1, 1'b0, 6'h01, 16'h0000);
      t_ind(1'b0, 1'b0, 6'h02, 16'h1234);
      t_ind(1'b1, 1'b0, 6'h03, 16'h2000);
      t_ind(1'b1, 1'b1, 6'h20, 16'h3010);
      t_ind(1'b0, 1'b1, 6'h1f, 16'hffe8);
      results();
   end
endmodule
